// >>> hdl/idpc_defines.svh
// constants of the iq data port control block
// assumes inclusion by bare name from package and modules
`ifndef IDPC_DEFINES_SVH
`define IDPC_DEFINES_SVH

// data_port_control field positions
`define IDPC_BIT_READ_EFF_FTW   16
`define IDPC_FLD_PRESCALE_HI    15
`define IDPC_FLD_PRESCALE_LO    14
`define IDPC_BIT_HALF_RATE      13
`define IDPC_BIT_OFFSET_BIN     12
`define IDPC_BIT_CLK_ENABLE     11
`define IDPC_BIT_CLK_INVERT     10
`define IDPC_BIT_GATE_INVERT    9
`define IDPC_BIT_Q_FIRST        8
`define IDPC_BIT_HOLD_LAST      6
`define IDPC_BIT_SYNC_VAL_DIS   5

// implemented bits 16:8, 6:5; all others read zero
`define IDPC_CTRL_MASK          32'h0001_ff60
`define IDPC_CTRL_RESET         32'h0000_0820

// primary_mode_control mode field codes
`define IDPC_MODE_QUADRATURE    2'h0
`define IDPC_MODE_SINGLE_TONE   2'h1

// update timer prescale codes
`define IDPC_DIV_1              2'h0
`define IDPC_DIV_2              2'h1
`define IDPC_DIV_4              2'h2
`define IDPC_DIV_8              2'h3

`define IDPC_WORD_W             18
`define IDPC_BUF_DEPTH          2

`endif

// >>> hdl/idpc_pkg.sv
// types shared by the iq data port control block
// assumes idpc_defines.svh is on the include path
`include "idpc_defines.svh"

package idpc_pkg;

	typedef logic [`IDPC_WORD_W-1:0] idpc_word_t;

	typedef enum logic [1:0] {
		SLOT_FIRST  = 2'b00,
		SLOT_SECOND = 2'b01,
		SLOT_STALL  = 2'b10
	} idpc_slot_t;

endpackage

// >>> hdl/idpc_stream_if.sv
// i/q pair stream between assembler and buffer
// assumes a single clock shared by both ends
`timescale 1ns/100ps
`default_nettype none

interface idpc_stream_if;
	import idpc_pkg::*;

	logic       valid;
	logic       ready;
	idpc_word_t iWord;
	idpc_word_t qWord;

	modport src (output valid, output iWord, output qWord, input ready);
	modport snk (input valid, input iWord, input qWord, output ready);
endinterface

`default_nettype wire

// >>> hdl/idpc_pair_buffer.sv
// two-entry i/q pair buffer, flip-flop storage
// assumes clk_sys domain only; valid comes straight from a flop, ready is decoded from count_r
`timescale 1ns/100ps
`default_nettype none
`include "idpc_defines.svh"

module idpc_pair_buffer
	import idpc_pkg::*;
(
	input  wire logic   clk_sys,  // system clock
	input  wire logic   rst,      // async reset, high
	idpc_stream_if.snk  fill,     // from assembler
	idpc_stream_if.src  drain     // toward baseband path
);

	idpc_word_t memI_r [`IDPC_BUF_DEPTH];
	idpc_word_t memQ_r [`IDPC_BUF_DEPTH];
	idpc_word_t memI_nxt [`IDPC_BUF_DEPTH];
	idpc_word_t memQ_nxt [`IDPC_BUF_DEPTH];
	logic       wrIdx_r, wrIdx_nxt;
	logic       rdIdx_r, rdIdx_nxt;
	logic [1:0] count_r, count_nxt;
	logic       push;
	logic       pop;
	// head kept in its own flops so the drain outputs leave from flops
	logic       headValid_r, headValid_nxt;
	idpc_word_t headI_r, headI_nxt;
	idpc_word_t headQ_r, headQ_nxt;

	assign fill.ready  = (count_r != 2'h2);
	assign drain.valid = headValid_r;
	assign drain.iWord = headI_r;
	assign drain.qWord = headQ_r;

	always_comb begin
		push      = fill.valid && (count_r != 2'h2);
		pop       = drain.ready && (count_r != 2'h0);
		memI_nxt  = memI_r;
		memQ_nxt  = memQ_r;
		wrIdx_nxt = wrIdx_r;
		rdIdx_nxt = rdIdx_r;
		count_nxt = count_r;
		if (push) begin
			memI_nxt[wrIdx_r] = fill.iWord;
			memQ_nxt[wrIdx_r] = fill.qWord;
			wrIdx_nxt         = ~wrIdx_r;
		end
		if (pop) begin
			rdIdx_nxt = ~rdIdx_r;
		end
		case ({push, pop})
			2'b10:   count_nxt = count_r + 2'h1;
			2'b01:   count_nxt = count_r - 2'h1;
			default: count_nxt = count_r;
		endcase
		headValid_nxt = (count_nxt != 2'h0);
		headI_nxt     = memI_nxt[rdIdx_nxt];
		headQ_nxt     = memQ_nxt[rdIdx_nxt];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int k = 0; k < `IDPC_BUF_DEPTH; k++) begin
				memI_r[k] <= '0;
				memQ_r[k] <= '0;
			end
			wrIdx_r <= 1'b0;
			rdIdx_r <= 1'b0;
			count_r <= 2'h0;
			headValid_r <= 1'b0;
			headI_r     <= '0;
			headQ_r     <= '0;
		end else begin
			memI_r  <= memI_nxt;
			memQ_r  <= memQ_nxt;
			wrIdx_r <= wrIdx_nxt;
			rdIdx_r <= rdIdx_nxt;
			count_r <= count_nxt;
			headValid_r <= headValid_nxt;
			headI_r     <= headI_nxt;
			headQ_r     <= headQ_nxt;
		end
	end

endmodule

`default_nettype wire

// >>> hdl/iq_data_port_control.sv
// data port control register, parallel i/q data assembler,
// sample pair clock, update prescaler and sync timing checker
// assumes: clk_sys is the word clock; source samples pins on clk_sys
//
// What this block does
// - bit 16 set makes a tuning word read return the effective word.
// - bits 15:14 prescale the update timer clock by 1, 2, 4 or 8.
// - bit 13 runs the sample pair clock at half rate in parallel quad mode.
// - bit 12 reads input words as two's complement (0) or offset binary.
// - bit 11 clear holds the clock pin low while the assembler keeps time.
// - bit 10 inverts the clock level that marks a Q word (high = Q).
// - bit 9 inverts the transmit gate so that low means transmit.
// - bit 8 selects Q first instead of I first within a pair.
// - with the gate off, input is ignored and zeros or the last pair fill.
// - bit 5 clear lets the sync checker latch a possible violation.
// - bit 5 set resets the sync checker and forces its output to 0.
// - reset leaves bits 11 and 5 set and every other bit clear.
// - mode code 00b is quadrature modulation, which uses the data port.
// - mode code 01b is single tone, which leaves the i/q path unused.
// - serial mode bit clear means all 18 pins form the parallel port.
// - internal update on lets the update timer tick; off idles the timer.
`timescale 1ns/100ps
`default_nettype none
`include "idpc_defines.svh"

module iq_data_port_control
	import idpc_pkg::*;
(
	input  wire logic        clk_sys,              // system clock, 10 MHz
	input  wire logic        rst,                  // async reset, high
	input  wire logic        ctrlWrite,            // register write strobe
	input  wire logic [31:0] ctrlWriteData,        // register write data
	output logic      [31:0] ctrlReadData_r,       // register readback
	input  wire logic [31:0] ftwStored,            // tuning word as stored
	input  wire logic [31:0] ftwEffective,         // word at accumulator
	output logic      [31:0] ftwReadback_r,        // tuning word readback
	input  wire logic [1:0]  primaryMode,          // primary mode field
	input  wire logic        serialPortMode,       // serial data port on
	input  wire logic        internalUpdate,       // internal update on
	input  wire logic        transmitGate,         // transmit gate pin
	input  wire idpc_word_t  dataIn,               // parallel data pins
	output logic             samplePairClock_r,    // sample pair clock pin
	output logic             updateTimerTick_r,    // prescaled timer tick
	input  wire logic        syncViolation,        // sampled margin fault
	output logic             syncTimingError_r,    // sync error pin
	output logic             iqValid_r,            // pair available
	input  wire logic        iqReady,              // baseband takes pair
	output idpc_word_t       iOut_r,               // I word, two's compl.
	output idpc_word_t       qOut_r                // Q word, two's compl.
);

	// offset binary differs from two's complement only in the sign bit
	function automatic idpc_word_t toTwos(input idpc_word_t w,
		input logic offsetBin);
		toTwos = offsetBin ? {~w[`IDPC_WORD_W-1], w[`IDPC_WORD_W-2:0]} : w;
	endfunction

	////////////////////////////////////////////////////////////////////
	// control register

	logic [31:0] ctrl_r, ctrl_nxt;
	logic        readEffFtw, halfRate, offsetBin, clkEnable, clkInvert;
	logic        gateInvert, qFirst, holdLast, syncValDis;
	logic [1:0]  prescale;

	assign readEffFtw = ctrl_r[`IDPC_BIT_READ_EFF_FTW];
	assign prescale   = ctrl_r[`IDPC_FLD_PRESCALE_HI:`IDPC_FLD_PRESCALE_LO];
	assign halfRate   = ctrl_r[`IDPC_BIT_HALF_RATE];
	assign offsetBin  = ctrl_r[`IDPC_BIT_OFFSET_BIN];
	assign clkEnable  = ctrl_r[`IDPC_BIT_CLK_ENABLE];
	assign clkInvert  = ctrl_r[`IDPC_BIT_CLK_INVERT];
	assign gateInvert = ctrl_r[`IDPC_BIT_GATE_INVERT];
	assign qFirst     = ctrl_r[`IDPC_BIT_Q_FIRST];
	assign holdLast   = ctrl_r[`IDPC_BIT_HOLD_LAST];
	assign syncValDis = ctrl_r[`IDPC_BIT_SYNC_VAL_DIS];

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (ctrlWrite) begin
			ctrl_nxt = ctrlWriteData & `IDPC_CTRL_MASK;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_r <= `IDPC_CTRL_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// readback

	logic [31:0] ftwRead_nxt;

	always_comb begin
		ftwRead_nxt = readEffFtw ? ftwEffective : ftwStored;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrlReadData_r <= `IDPC_CTRL_RESET;
			ftwReadback_r  <= 32'h0000_0000;
		end else begin
			ctrlReadData_r <= ctrl_nxt;
			ftwReadback_r  <= ftwRead_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// update timer prescaler

	logic [2:0] preCnt_r, preCnt_nxt;
	logic [2:0] preLast;
	logic       tick_nxt;

	always_comb begin
		case (prescale)
			`IDPC_DIV_1: preLast = 3'h0;
			`IDPC_DIV_2: preLast = 3'h1;
			`IDPC_DIV_4: preLast = 3'h3;
			`IDPC_DIV_8: preLast = 3'h7;
			default:     preLast = 3'h0;
		endcase
		preCnt_nxt = 3'h0;
		tick_nxt   = 1'b0;
		// timer idles unless internal updates are selected
		if (internalUpdate) begin
			if (preCnt_r >= preLast) begin
				tick_nxt = 1'b1;
			end else begin
				preCnt_nxt = preCnt_r + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			preCnt_r          <= 3'h0;
			updateTimerTick_r <= 1'b0;
		end else begin
			preCnt_r          <= preCnt_nxt;
			updateTimerTick_r <= tick_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sync timing checker

	logic syncErr_nxt;

	always_comb begin
		if (syncValDis) begin
			syncErr_nxt = 1'b0;
		end else begin
			// latched: only the disable bit or reset clears it
			syncErr_nxt = syncTimingError_r | syncViolation;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			syncTimingError_r <= 1'b0;
		end else begin
			syncTimingError_r <= syncErr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// data assembler and sample pair clock

	idpc_stream_if asmIf ();
	idpc_stream_if outIf ();

	idpc_slot_t slot_r, slot_nxt;
	idpc_word_t first_r, first_nxt;
	idpc_word_t pairI_r, pairI_nxt;
	idpc_word_t pairQ_r, pairQ_nxt;
	idpc_word_t lastI_r, lastI_nxt;
	idpc_word_t lastQ_r, lastQ_nxt;
	logic       pairTgl_r, pairTgl_nxt;
	logic       clk_nxt;
	logic       quadPort;
	logic       txActive;
	logic       nxtIsQ;
	logic       level;
	idpc_word_t conv;

	// parallel port only in quadrature mode; single tone leaves it idle
	assign quadPort = (primaryMode == `IDPC_MODE_QUADRATURE)
		&& !serialPortMode;
	assign txActive = transmitGate ^ gateInvert;

	assign asmIf.valid = (slot_r == SLOT_STALL);
	assign asmIf.iWord = pairI_r;
	assign asmIf.qWord = pairQ_r;

	always_comb begin
		slot_nxt    = slot_r;
		first_nxt   = first_r;
		pairI_nxt   = pairI_r;
		pairQ_nxt   = pairQ_r;
		lastI_nxt   = lastI_r;
		lastQ_nxt   = lastQ_r;
		pairTgl_nxt = pairTgl_r;
		conv        = toTwos(dataIn, offsetBin);
		case (slot_r)
			SLOT_FIRST: begin
				if (quadPort) begin
					first_nxt = conv;
					slot_nxt  = SLOT_SECOND;
				end
			end
			SLOT_SECOND: begin
				// pair order on the pins
				pairI_nxt = qFirst ? conv : first_r;
				pairQ_nxt = qFirst ? first_r : conv;
				if (!txActive) begin
					pairI_nxt = holdLast ? lastI_r : '0;
					pairQ_nxt = holdLast ? lastQ_r : '0;
				end
				lastI_nxt   = pairI_nxt;
				lastQ_nxt   = pairQ_nxt;
				pairTgl_nxt = ~pairTgl_r;
				slot_nxt    = SLOT_STALL;
			end
			SLOT_STALL: begin
				// clock freezes here, so a full buffer holds off the source
				if (asmIf.ready) begin
					slot_nxt = SLOT_FIRST;
				end
			end
			default: slot_nxt = SLOT_FIRST;
		endcase
		if (!quadPort && slot_nxt == SLOT_SECOND) begin
			slot_nxt = SLOT_FIRST;
		end
		// at full rate, level announces the word of the coming slot
		nxtIsQ = (slot_nxt == SLOT_SECOND) ? !qFirst : qFirst;
		level  = halfRate ? pairTgl_nxt : nxtIsQ;
		level  = level ^ clkInvert;
		if (slot_nxt == SLOT_STALL || !quadPort) begin
			level = samplePairClock_r;
		end
		clk_nxt = clkEnable ? level : 1'b0;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			slot_r            <= SLOT_FIRST;
			first_r           <= '0;
			pairI_r           <= '0;
			pairQ_r           <= '0;
			lastI_r           <= '0;
			lastQ_r           <= '0;
			pairTgl_r         <= 1'b0;
			samplePairClock_r <= 1'b0;
		end else begin
			slot_r            <= slot_nxt;
			first_r           <= first_nxt;
			pairI_r           <= pairI_nxt;
			pairQ_r           <= pairQ_nxt;
			lastI_r           <= lastI_nxt;
			lastQ_r           <= lastQ_nxt;
			pairTgl_r         <= pairTgl_nxt;
			samplePairClock_r <= clk_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pair buffer toward the baseband path

	idpc_pair_buffer idpc_pair_buffer_i (
		.clk_sys (clk_sys),
		.rst     (rst),
		.fill    (asmIf.snk),
		.drain   (outIf.src)
	);

	assign outIf.ready = iqReady;
	assign iqValid_r   = outIf.valid;
	assign iOut_r      = outIf.iWord;
	assign qOut_r      = outIf.qWord;

endmodule

`default_nettype wire

// >>> sim/idpc_port_monitor.sv
// concurrent checks on the iq data port control ports
// assumes binding onto iq_data_port_control, one clock domain
`timescale 1ns/100ps
`default_nettype none

module idpc_port_monitor
	import idpc_pkg::*;
(
	input wire logic        clk_sys,           // clock
	input wire logic        rst,               // async reset, high
	input wire logic        ctrlWrite,         // write strobe
	input wire logic [31:0] ctrlWriteData,     // write data
	input wire logic [31:0] ctrlReadData_r,    // register value
	input wire logic [31:0] ftwStored,         // stored word
	input wire logic [31:0] ftwEffective,      // effective word
	input wire logic [31:0] ftwReadback_r,     // word readback
	input wire logic        internalUpdate,    // update timer on
	input wire logic        updateTimerTick_r, // timer tick
	input wire logic        syncViolation,     // margin fault
	input wire logic        syncTimingError_r, // sync error pin
	input wire logic        samplePairClock_r, // clock pin
	input wire logic        iqValid_r,         // pair available
	input wire logic        iqReady,           // pair taken
	input wire idpc_word_t  iOut_r,            // I word
	input wire idpc_word_t  qOut_r             // Q word
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence tickGap8;
		!updateTimerTick_r [*7] ##1 updateTimerTick_r;
	endsequence
	// config must stay put, else the gap check is void
	sequence div8Held;
		(ctrlReadData_r[15:14] == 2'h3 && internalUpdate) [*8];
	endsequence

	write_mask_a: assert property (ctrlWrite |=>
		ctrlReadData_r == ($past(ctrlWriteData) & 32'h0001ff60))
		else $error("readback differs from masked write");
	reserved_zero_a: assert property (
		ctrlReadData_r[31:17] == 15'h0 &&
		ctrlReadData_r[7] == 1'b0 && ctrlReadData_r[4:0] == 5'h0)
		else $error("unassigned bit reads one");
	ftw_source_a: assert property (1'b1 |=> ftwReadback_r ==
		($past(ctrlReadData_r[16]) ? $past(ftwEffective) : $past(ftwStored)))
		else $error("tuning word readback from wrong source");
	tick_gap_a: assert property (updateTimerTick_r &&
		ctrlReadData_r[15:14] == 2'h3 && internalUpdate |=>
		(div8Held implies tickGap8))
		else $error("divide by eight tick spacing wrong");
	tick_idle_a: assert property (!internalUpdate
		##1 !internalUpdate |-> !updateTimerTick_r)
		else $error("tick without internal update");
	pin_off_a: assert property (!ctrlReadData_r[11] ##1
		!ctrlReadData_r[11] |-> !samplePairClock_r)
		else $error("clock pin moves while disabled");
	sync_clear_a: assert property (ctrlReadData_r[5] |=>
		!syncTimingError_r)
		else $error("sync error high while disabled");
	sync_catch_a: assert property (!ctrlReadData_r[5] &&
		syncViolation |=> syncTimingError_r)
		else $error("sync violation not flagged");
	sync_sticky_a: assert property (!ctrlReadData_r[5] &&
		syncTimingError_r |=> syncTimingError_r)
		else $error("sync error dropped while enabled");
	pair_hold_a: assert property (iqValid_r && !iqReady |=>
		iqValid_r && $stable(iOut_r) && $stable(qOut_r))
		else $error("pair changed while stalled");
endmodule

bind iq_data_port_control idpc_port_monitor idpc_port_monitor_i (
	.clk_sys(clk_sys), .rst(rst), .ctrlWrite(ctrlWrite),
	.ctrlWriteData(ctrlWriteData), .ctrlReadData_r(ctrlReadData_r),
	.ftwStored(ftwStored), .ftwEffective(ftwEffective),
	.ftwReadback_r(ftwReadback_r), .internalUpdate(internalUpdate),
	.updateTimerTick_r(updateTimerTick_r), .syncViolation(syncViolation),
	.syncTimingError_r(syncTimingError_r),
	.samplePairClock_r(samplePairClock_r), .iqValid_r(iqValid_r),
	.iqReady(iqReady), .iOut_r(iOut_r), .qOut_r(qOut_r));

`default_nettype wire

// >>> sim/idpc_source_model.sv
// baseband source that drives the parallel data pins
// assumes the clock pin level names the word being sampled
`timescale 1ns/100ps
`default_nettype none

module idpc_source_model
	import idpc_pkg::*;
(
	input  wire logic       pinLevel,   // sample pair clock pin
	input  wire logic       clkInvert,  // polarity setting
	input  wire logic       offsetBin,  // number format setting
	input  wire logic       portActive, // parallel port in use
	input  wire idpc_word_t iVal,       // I sample, two's complement
	input  wire idpc_word_t qVal,       // Q sample, two's complement
	output wire idpc_word_t dataIn      // data pins
);
	idpc_word_t word;
	idpc_word_t lastWord = '0;

	always_comb begin
		word = (pinLevel ^ clkInvert) ? qVal : iVal;
		word[17] = word[17] ^ offsetBin;
	end
	always @* begin
		if (portActive)
			lastWord = word;
	end
	// released pins show the inverse so stale data is never mistaken
	assign dataIn = portActive ? word : ~lastWord;
endmodule

`default_nettype wire

// >>> sim/test_iq_data_port_control.sv
// self-checking bench for iq_data_port_control
// assumes the source model answers on the pin level
`timescale 1ns/100ps
`default_nettype none

module test_iq_data_port_control;
	import idpc_pkg::*;
	logic        clk_sys, rst, ctrlWrite, serialPortMode, internalUpdate;
	logic        transmitGate, syncViolation, iqReady, prevPin;
	logic        samplePairClock_r, updateTimerTick_r, syncTimingError_r;
	logic        iqValid_r;
	logic [1:0]  primaryMode;
	logic [31:0] ctrlWriteData, ftwStored, ftwEffective, cfg, w;
	logic [31:0] ctrlReadData_r, ftwReadback_r;
	idpc_word_t  dataIn, iOut_r, qOut_r, iVal, qVal, oldI;
	int          numErrors = 0, cmpCount = 0, cycles = 0, cnt;

	iq_data_port_control iq_data_port_control_i (.clk_sys(clk_sys),
		.rst(rst), .ctrlWrite(ctrlWrite), .ctrlWriteData(ctrlWriteData),
		.ctrlReadData_r(ctrlReadData_r), .ftwStored(ftwStored),
		.ftwEffective(ftwEffective), .ftwReadback_r(ftwReadback_r),
		.primaryMode(primaryMode), .serialPortMode(serialPortMode),
		.internalUpdate(internalUpdate), .transmitGate(transmitGate),
		.dataIn(dataIn), .samplePairClock_r(samplePairClock_r),
		.updateTimerTick_r(updateTimerTick_r),
		.syncViolation(syncViolation), .syncTimingError_r(syncTimingError_r),
		.iqValid_r(iqValid_r), .iqReady(iqReady), .iOut_r(iOut_r),
		.qOut_r(qOut_r));
	idpc_source_model idpc_source_model_i (.pinLevel(samplePairClock_r),
		.clkInvert(cfg[10]), .offsetBin(cfg[12]),
		.portActive(primaryMode == 2'h0 && !serialPortMode),
		.iVal(iVal), .qVal(qVal), .dataIn(dataIn));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			$display("ERROR %0t run timed out", $time);
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			numErrors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] d);
		@(negedge clk_sys);
		ctrlWrite = 1'b1;
		ctrlWriteData = d;
		cfg = d;
		@(negedge clk_sys);
		ctrlWrite = 1'b0;
	endtask
	task automatic waitPair();
		int n;
		n = 0;
		while (iqValid_r !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	function automatic logic [31:0] expRead(input logic [31:0] d);
		return d & 32'h0001ff60;
	endfunction
	function automatic idpc_word_t expFill(input logic hold, idpc_word_t v);
		return hold ? v : 18'h0;
	endfunction
	task results();
		$display("comparisons %0d mismatches %0d", cmpCount, numErrors);
		if (numErrors == 0 && cmpCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		ctrlWrite = 1'b0;
		ctrlWriteData = 32'h0;
		cfg = 32'h820;
		ftwStored = 32'h0;
		ftwEffective = 32'h0;
		primaryMode = 2'h0;
		serialPortMode = 1'b0;
		internalUpdate = 1'b0;
		transmitGate = 1'b1;
		syncViolation = 1'b0;
		iqReady = 1'b1;
		iVal = 18'h0;
		qVal = 18'h0;
		void'($urandom(32'hcd994e0a));
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
		chk(ctrlReadData_r, 32'h0000_0820);
		chk({31'h0, syncTimingError_r}, 32'h0);
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			w = (k == 0) ? 32'hffff_ffff : $urandom;
			wr(w);
			chk(ctrlReadData_r, expRead(w));
		end
		ftwStored = $urandom;
		ftwEffective = $urandom;
		for (int k = 0; k < 2; k++) begin
			wr({15'h0, k[0], 16'h0});
			@(negedge clk_sys);
			chk(ftwReadback_r, k ? ftwEffective : ftwStored);
		end
		$display("test register done");
		wr(32'h0);
		syncViolation = 1'b1;
		@(negedge clk_sys);
		syncViolation = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk({31'h0, syncTimingError_r}, 32'h1);
		wr(32'h20);
		syncViolation = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk({31'h0, syncTimingError_r}, 32'h0);
		syncViolation = 1'b0;
		$display("test sync done");
		for (int d = 0; d < 5; d++) begin
			internalUpdate = (d < 4);
			wr({16'h0, 2'(d), 14'h0});
			repeat (8) @(negedge clk_sys);
			cnt = 0;
			repeat (64) begin
				@(negedge clk_sys);
				cnt += updateTimerTick_r;
			end
			chk(32'(cnt), (d < 4) ? 32'(64 >> d) : 32'h0);
		end
		$display("test timer done");
		for (int k = 0; k < 5; k++) begin
			primaryMode = (k == 3) ? 2'h1 : 2'h0;
			serialPortMode = (k == 4);
			wr((k == 0 || k >= 3) ? 32'h800 : (k == 1) ? 32'h2800 : 32'h0);
			repeat (6) @(negedge clk_sys);
			cnt = 0;
			prevPin = samplePairClock_r;
			repeat (60) begin
				@(negedge clk_sys);
				cnt += (samplePairClock_r !== prevPin);
				prevPin = samplePairClock_r;
			end
			w = (k == 0) ? 32'd40 : (k == 1) ? 32'd20 : 32'd0;
			chk(32'(cnt), w);
		end
		primaryMode = 2'h0;
		serialPortMode = 1'b0;
		$display("test clock pin done");
		for (int k = 0; k < 8; k++) begin
			iVal = 18'($urandom);
			qVal = (k == 7) ? 18'h20000 : 18'($urandom);
			wr({19'h0, k[2], 1'b1, k[1], 1'b0, k[0], 8'h0});
			iqReady = 1'b0;
			repeat (10) @(negedge clk_sys);
			iqReady = 1'b1;
			repeat (15) @(negedge clk_sys);
			waitPair();
			chk({31'h0, iqValid_r}, 32'h1);
			chk({14'h0, iOut_r}, {14'h0, iVal});
			chk({14'h0, qOut_r}, {14'h0, qVal});
		end
		$display("test data port done");
		for (int k = 0; k < 4; k++) begin
			wr({22'h0, k[0], 2'h0, k[1], 6'h0} | 32'h800);
			transmitGate = ~k[0];
			iVal = 18'($urandom);
			qVal = 18'($urandom);
			oldI = iVal;
			repeat (15) @(negedge clk_sys);
			transmitGate = k[0];
			iVal = 18'($urandom);
			repeat (15) @(negedge clk_sys);
			waitPair();
			chk({14'h0, iOut_r}, {14'h0, expFill(k[1], oldI)});
			chk({14'h0, qOut_r}, {14'h0, expFill(k[1], qVal)});
		end
		$display("test gate done");
		results();
	end
endmodule

`default_nettype wire
